// file: hdl/dcc_cfg.svh
// Purpose: Constants for the dual comparator control register bank.
// Assumes: 8-bit register port, 100 MHz clk_sys.
// Notes:   Offsets are register-space addresses; page selects comparator bank.
// Overview of operation
// (RULE1) Control bit 7 powers first comparator
// (RULE2) Control bit 6 reads comparator result
// (RULE3) Control bit 5 sets on rising edge
// (RULE4) Control bit 4 sets on falling edge
// (RULE5) Bits 3-2 pick positive hysteresis level
// (RULE6) Bits 1-0 pick negative hysteresis level
// (RULE7) Control registers reset to all zeros
// (RULE8) Mode bit 5 enables rising interrupt
// (RULE9) Mode bit 4 enables falling interrupt
// (RULE10) Mode bits 1-0 pick response speed
// (RULE11) Mode bits 7-6, 3-2 read zero
// (RULE12) Mode registers reset to 0x02
// (RULE13) First bank: page 1, 0x88/0x89
// (RULE14) Second control register at 0x88 too
// (RULE15) Second comparator edges flag independently
// (RULE16) Second mode register: page 2, 0x89
// (RULE17) Output unsettled 20 us after enable
// (RULE18) Edge flags clear only by software
// (RULE19) Disabled comparator: pin low, no interrupt
// (RULE20) Software clears flags before enabling interrupts
// (RULE21) Interrupt when flag and enable both set
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH

`define DCC_ADDR_CTRL 8'h88
`define DCC_ADDR_MODE 8'h89
`define DCC_PAGE_FIRST 8'h01
`define DCC_PAGE_SECOND 8'h02
`define DCC_CTRL_RESET 8'h00
`define DCC_MODE_RESET 8'h02
`define DCC_MODE_MASK 8'h33
`define DCC_BIT_EN 7
`define DCC_BIT_OUT 6
`define DCC_BIT_RISE 5
`define DCC_BIT_FALL 4
`define DCC_BIT_RIE 5
`define DCC_BIT_FIE 4
`define DCC_POWERUP_NS 20000
`define DCC_CLK_NS 10
`define DCC_POWERUP_CYC ((`DCC_POWERUP_NS + `DCC_CLK_NS - 1) / `DCC_CLK_NS)

`endif

// file: hdl/dcc_pkg.sv
// Purpose: Types for the dual comparator control register bank.
// Assumes: Included constants from dcc_cfg.svh.
// Notes:   Register access and analog control travel as packed structs.
package dcc_pkg;
    // Register port request from the processor
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dcc_req_s;

    // Per-comparator settings driven to the analog core
    typedef struct packed {
        logic powerOn;
        logic [1:0] posHyst;
        logic [1:0] negHyst;
        logic [1:0] speedSel;
    } dcc_ana_s;
endpackage

// file: hdl/dcc_comparator_regs.sv
// Purpose: Control and mode registers for two comparators, with edge flags.
// Assumes: Register writes and reads are single-cycle strobes on clk_sys.
// Notes:   Comparator results are asynchronous and pass two flip-flops.
`timescale 1ns/1ns
`default_nettype none
`include "dcc_cfg.svh"

module dcc_comparator_regs #(
    parameter int unsigned POWERUP_CYC = `DCC_POWERUP_CYC
) (
    input wire logic clk_sys,                 // System clock, 100 MHz
    input wire logic resetn,                  // Async reset, active low
    input wire dcc_pkg::dcc_req_s regReq,     // Register access request
    input wire logic [1:0] cmpRaw,            // Raw analog comparator outputs
    output logic [7:0] regRdata,              // Read data, valid after rd
    output dcc_pkg::dcc_ana_s firstAna,       // First comparator core settings
    output dcc_pkg::dcc_ana_s secondAna,      // Second comparator core settings
    output logic [1:0] cmpPinOut,             // Comparator outputs toward pins
    output logic [1:0] cmpIrq,                // Interrupt requests, level
    output logic [1:0] cmpSettled             // Output past power-up time
);

    // ----------------------------------------
    // Decoding helpers
    // ----------------------------------------
    function automatic logic hitReg(input dcc_pkg::dcc_req_s r, input logic [7:0] pg, input logic [7:0] ad);
        hitReg = (r.page == pg) && (r.addr == ad);
    endfunction

    // ----------------------------------------
    // Input synchroniser
    // ----------------------------------------
    logic [1:0] cmpMeta;
    logic [1:0] cmpSync;
    logic [1:0] cmpPrev;

    // Raw results come from analog, so two flops before any use
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cmpMeta <= 2'h0;
            cmpSync <= 2'h0;
            cmpPrev <= 2'h0;
        end else begin
            cmpMeta <= cmpRaw;
            cmpSync <= cmpMeta;
            cmpPrev <= cmpSync;
        end
    end

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [7:0] ctrl [2];
    logic [7:0] mode [2];
    logic [7:0] next_ctrl [2];
    logic [7:0] next_mode [2];
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic [7:0] pageOf [2];

    assign pageOf[0] = `DCC_PAGE_FIRST;
    assign pageOf[1] = `DCC_PAGE_SECOND;

    // Next register values; hardware flag set beats a software clear
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            next_ctrl[i] = ctrl[i];
            next_mode[i] = mode[i];
            if (regReq.wr && hitReg(regReq, pageOf[i], `DCC_ADDR_CTRL)) begin
                next_ctrl[i] = regReq.wdata;                                     // [RULE1] [RULE5] [RULE6] [RULE14]
            end
            if (regReq.wr && hitReg(regReq, pageOf[i], `DCC_ADDR_MODE)) begin
                next_mode[i] = regReq.wdata & `DCC_MODE_MASK;                    // [RULE11] [RULE13] [RULE16]
            end
            // Result bit is hardware-owned; software writes to it are dropped
            next_ctrl[i][`DCC_BIT_OUT] = cmpSync[i] & ctrl[i][`DCC_BIT_EN];     // [RULE2]
            // Edge flags: set by edges or by writes, cleared only by writes
            if (cmpSync[i] && !cmpPrev[i] && ctrl[i][`DCC_BIT_EN]) begin
                next_ctrl[i][`DCC_BIT_RISE] = 1'b1;                              // [RULE3] [RULE15] [RULE18]
            end
            if (!cmpSync[i] && cmpPrev[i] && ctrl[i][`DCC_BIT_EN]) begin
                next_ctrl[i][`DCC_BIT_FALL] = 1'b1;                              // [RULE4] [RULE15] [RULE18]
            end
        end
        next_rdata = 8'h00;
        if (regReq.rd) begin
            for (int i = 0; i < 2; i++) begin
                if (hitReg(regReq, pageOf[i], `DCC_ADDR_CTRL)) begin
                    next_rdata = ctrl[i];
                end
                if (hitReg(regReq, pageOf[i], `DCC_ADDR_MODE)) begin
                    next_rdata = mode[i] & `DCC_MODE_MASK;                      // [RULE11]
                end
            end
        end
    end

    // Register update; reset leaves comparators off, mode 2
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 2; i++) begin
                ctrl[i] <= `DCC_CTRL_RESET;                                      // [RULE7]
                mode[i] <= `DCC_MODE_RESET;                                      // [RULE12]
            end
            rdata <= 8'h00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                ctrl[i] <= next_ctrl[i];
                mode[i] <= next_mode[i];
            end
            rdata <= next_rdata;
        end
    end

    // ----------------------------------------
    // Power-up settle timers
    // ----------------------------------------
    logic [15:0] settleCnt [2];
    logic [15:0] next_settleCnt [2];
    logic [1:0] enPrev;

    // Count restarts on every enable rising edge; disabled means unsettled
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            next_settleCnt[i] = settleCnt[i];
            if (!ctrl[i][`DCC_BIT_EN] || !enPrev[i]) begin
                next_settleCnt[i] = 16'h0000;                                    // [RULE17]
            end else if (settleCnt[i] < 16'(POWERUP_CYC)) begin
                next_settleCnt[i] = settleCnt[i] + 16'h0001;                     // [RULE17]
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            settleCnt[0] <= 16'h0000;
            settleCnt[1] <= 16'h0000;
            enPrev <= 2'h0;
        end else begin
            settleCnt[0] <= next_settleCnt[0];
            settleCnt[1] <= next_settleCnt[1];
            enPrev <= {ctrl[1][`DCC_BIT_EN], ctrl[0][`DCC_BIT_EN]};
        end
    end

    // ----------------------------------------
    // Outputs, all registered
    // ----------------------------------------
    dcc_pkg::dcc_ana_s next_firstAna;
    dcc_pkg::dcc_ana_s next_secondAna;
    logic [1:0] next_pin;
    logic [1:0] next_irq;
    logic [1:0] next_settled;

    // Interrupts gated by enable; software must clear stale flags first
    always_comb begin
        next_firstAna = {next_ctrl[0][7], next_ctrl[0][3:2], next_ctrl[0][1:0], next_mode[0][1:0]}; // [RULE1] [RULE5] [RULE10]
        next_secondAna = {next_ctrl[1][7], next_ctrl[1][3:2], next_ctrl[1][1:0], next_mode[1][1:0]};
        for (int i = 0; i < 2; i++) begin
            next_pin[i] = next_ctrl[i][`DCC_BIT_EN] & next_ctrl[i][`DCC_BIT_OUT];          // [RULE19]
            next_irq[i] = next_ctrl[i][`DCC_BIT_EN] &
                ((next_ctrl[i][`DCC_BIT_RISE] & next_mode[i][`DCC_BIT_RIE]) |
                 (next_ctrl[i][`DCC_BIT_FALL] & next_mode[i][`DCC_BIT_FIE]));              // [RULE8] [RULE9] [RULE19] [RULE21]
            next_settled[i] = ctrl[i][`DCC_BIT_EN] && (settleCnt[i] >= 16'(POWERUP_CYC));  // [RULE17]
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            firstAna <= '{powerOn: 1'b0, posHyst: 2'h0, negHyst: 2'h0, speedSel: 2'h2};
            secondAna <= '{powerOn: 1'b0, posHyst: 2'h0, negHyst: 2'h0, speedSel: 2'h2};
            cmpPinOut <= 2'h0;
            cmpIrq <= 2'h0;
            cmpSettled <= 2'h0;
        end else begin
            firstAna <= next_firstAna;
            secondAna <= next_secondAna;
            cmpPinOut <= next_pin;
            cmpIrq <= next_irq;
            cmpSettled <= next_settled;
        end
    end

    assign regRdata = rdata;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence riseSeen_s;
        ctrl[0][`DCC_BIT_EN] && cmpSync[0] && !cmpPrev[0];
    endsequence

    flag_rise_set_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE3]
        riseSeen_s |=> ctrl[0][`DCC_BIT_RISE]) else $error("rise flag not set");
    flag_fall_set_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE4]
        (ctrl[1][`DCC_BIT_EN] && !cmpSync[1] && cmpPrev[1]) |=> ctrl[1][`DCC_BIT_FALL])
        else $error("fall flag not set");
    flag_sticky_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE18]
        (ctrl[0][`DCC_BIT_RISE] && !(regReq.wr && hitReg(regReq, `DCC_PAGE_FIRST, `DCC_ADDR_CTRL)))
        |=> ctrl[0][`DCC_BIT_RISE])
        else $error("rise flag lost");
    result_bit_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE2]
        ctrl[0][`DCC_BIT_EN] |=> ctrl[0][`DCC_BIT_OUT] == $past(cmpSync[0]))
        else $error("result bit mismatch");
    mode_unused_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE11]
        (mode[0] & ~`DCC_MODE_MASK) == 8'h00 && (mode[1] & ~`DCC_MODE_MASK) == 8'h00)
        else $error("unused mode bits set");
    pin_low_off_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE19]
        !ctrl[0][`DCC_BIT_EN] |-> !cmpPinOut[0] && !cmpIrq[0]) else $error("disabled comparator active");
    irq_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE21]
        cmpIrq[1] |-> (mode[1][`DCC_BIT_RIE] | mode[1][`DCC_BIT_FIE])) else $error("irq without enable");
    settle_time_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE17]
        $rose(ctrl[0][`DCC_BIT_EN]) |-> !cmpSettled[0] [*8]) else $error("settled too soon");
    speed_drive_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE10]
        secondAna.speedSel == mode[1][1:0]) else $error("speed select not driven");

endmodule
`default_nettype wire

// file: sim/dcc_core_model.sv
// Purpose: Behavioural pair of analog comparator cores facing the register bank.
// Assumes: Bench commands which input is higher; a small fixed response delay.
// Notes:   A core that is shut down gives a meaningless, toggling output.
`timescale 1ns/1ns
`default_nettype none

module dcc_core_model (
    input wire logic [1:0] powerOn, // Core power from the bank
    input wire logic [1:0] vHigh,   // Plus input above minus input
    output logic [1:0] cmpRaw       // Raw results toward the bank
);
    logic [1:0] vDly = 2'h0;
    logic junk = 1'b0;

    // Response lag; unrelated to clk_sys so edges land at any phase
    always @(vHigh) vDly <= #33 vHigh;
    // Shut-down core: output wanders, never holds a stale level
    always #7 junk = ~junk;
    assign cmpRaw = (powerOn & vDly) | (~powerOn & {2{junk}});
endmodule
`default_nettype wire

// file: sim/dual_comparator_control_regs_tb.sv
// Purpose: Self-checking bench for the dual comparator register bank.
// Assumes: Power-up count shortened to 20 cycles.
// Notes:   Table rows cover plain register access; edge and power cases follow.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin failures++; $display("BAD %0t %s", $time, m); end end

module dual_comparator_control_regs_tb;
    typedef struct packed {logic w; logic [7:0] pg; logic [7:0] ad; logic [7:0] wd; logic [7:0] ex;} dcc_row_s;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    dcc_pkg::dcc_req_s req = '0;
    logic [1:0] vHigh = 2'h0;
    logic [1:0] cmpRaw, cmpPinOut, cmpIrq, cmpSettled;
    logic [7:0] regRdata;
    dcc_pkg::dcc_ana_s firstAna, secondAna;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    dcc_row_s rows [10] = '{'{1'b0, 8'h01, 8'h88, 8'h00, 8'h00}, '{1'b0, 8'h01, 8'h89, 8'h00, 8'h02},
        '{1'b0, 8'h02, 8'h88, 8'h00, 8'h00}, '{1'b0, 8'h02, 8'h89, 8'h00, 8'h02},
        '{1'b1, 8'h01, 8'h88, 8'h4F, 8'h0F}, '{1'b1, 8'h01, 8'h89, 8'hFF, 8'h33},
        '{1'b1, 8'h02, 8'h89, 8'hCD, 8'h01}, '{1'b1, 8'h02, 8'h88, 8'h06, 8'h06},
        '{1'b1, 8'h03, 8'h88, 8'hFF, 8'h00}, '{1'b1, 8'h01, 8'h8A, 8'hFF, 8'h00}};

    dcc_comparator_regs #(.POWERUP_CYC(20)) DUT (.clk_sys(clk_sys), .resetn(resetn), .regReq(req),
        .cmpRaw(cmpRaw), .regRdata(regRdata), .firstAna(firstAna), .secondAna(secondAna),
        .cmpPinOut(cmpPinOut), .cmpIrq(cmpIrq), .cmpSettled(cmpSettled));
    dcc_core_model core (.powerOn({secondAna.powerOn, firstAna.powerOn}), .vHigh(vHigh), .cmpRaw(cmpRaw));

    // ----------------------------------------
    // Clock, timeout and verdict
    // ----------------------------------------
    always #5 clk_sys = ~clk_sys;
    // Run needs under two hundred cycles; a hang is cut well past that
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            close_out();
        end
    end

    task automatic close_out();
        if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // One register access; strobe held over exactly one taking edge
    task automatic acc(input logic w, input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] wd);
        @(posedge clk_sys);
        #1;
        req.wr = w;
        req.rd = ~w;
        req.page = pg;
        req.addr = ad;
        req.wdata = wd;
        @(posedge clk_sys);
        #1;
        req.wr = 1'b0;
        req.rd = 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        settle(2);
        #1 resetn = 1'b1;
        `CHK(firstAna, 7'h02, "reset ana")
        foreach (rows[i]) begin
            if (rows[i].w) acc(1'b1, rows[i].pg, rows[i].ad, rows[i].wd);
            acc(1'b0, rows[i].pg, rows[i].ad, 8'h00);
            `CHK(regRdata, rows[i].ex, "row read")
        end
        // Every hysteresis code reaches the first core, every speed code the second
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, 8'h01, 8'h88, {4'h0, i[1:0], ~i[1:0]});
            `CHK({firstAna.posHyst, firstAna.negHyst}, {i[1:0], ~i[1:0]}, "hyst")
            acc(1'b1, 8'h02, 8'h89, {6'h00, i[1:0]});
            `CHK(secondAna.speedSel, i[1:0], "speed")
        end
        acc(1'b1, 8'h01, 8'h89, 8'h00);
        acc(1'b1, 8'h01, 8'h88, 8'h80);
        `CHK({firstAna.powerOn, cmpSettled[0]}, 2'b10, "power on")
        settle(15);
        `CHK(cmpSettled[0], 1'b0, "settled early")
        settle(10);
        `CHK(cmpSettled[0], 1'b1, "settled late")
        // Flags are unknown after power-up, so clear before use
        acc(1'b1, 8'h01, 8'h88, 8'h80);
        vHigh[0] = 1'b1;
        settle(8);
        acc(1'b0, 8'h01, 8'h88, 8'h00);
        `CHK(regRdata, 8'hE0, "rise flag")
        `CHK({cmpPinOut[0], cmpIrq[0]}, 2'b10, "irq masked")
        acc(1'b1, 8'h01, 8'h89, 8'h20);
        `CHK(cmpIrq[0], 1'b1, "rise irq")
        vHigh[0] = 1'b0;
        settle(8);
        acc(1'b0, 8'h01, 8'h88, 8'h00);
        `CHK(regRdata, 8'hB0, "fall flag")
        acc(1'b1, 8'h01, 8'h89, 8'h10);
        `CHK(cmpIrq[0], 1'b1, "fall irq")
        acc(1'b1, 8'h01, 8'h88, 8'hA0);
        `CHK(cmpIrq[0], 1'b0, "fall cleared")
        // Second core runs on its own flags
        acc(1'b1, 8'h02, 8'h88, 8'h80);
        settle(25);
        acc(1'b1, 8'h02, 8'h88, 8'h80);
        vHigh[1] = 1'b1;
        settle(8);
        acc(1'b0, 8'h02, 8'h88, 8'h00);
        `CHK(regRdata, 8'hE0, "second rise")
        acc(1'b1, 8'h02, 8'h89, 8'h23);
        `CHK({cmpPinOut[1], cmpIrq[1]}, 2'b11, "second irq")
        acc(1'b0, 8'h01, 8'h88, 8'h00);
        `CHK(regRdata, 8'hA0, "first untouched")
        // Shut down with interrupt enabled and input high
        vHigh[0] = 1'b1;
        acc(1'b1, 8'h01, 8'h89, 8'h30);
        acc(1'b1, 8'h01, 8'h88, 8'h00);
        settle(8);
        `CHK({cmpPinOut[0], cmpIrq[0], firstAna.powerOn}, 3'b000, "disabled")
        // Reset in mid-run restores defaults
        #1 resetn = 1'b0;
        settle(2);
        #1 resetn = 1'b1;
        acc(1'b0, 8'h01, 8'h89, 8'h00);
        `CHK(regRdata, 8'h02, "mode after reset")
        acc(1'b0, 8'h02, 8'h88, 8'h00);
        `CHK(regRdata, 8'h00, "ctrl after reset")
        close_out();
    end
endmodule
`default_nettype wire
